// *** rspm_env_model.sv ***
// oscillators and external wake source around the manager.
// assumes the bench asks for wake through wake_req_i.
module rspm_env_model #(
    parameter int RC_PER = 10
)
(
    input  wire logic sys_clk_i,
    input  wire logic wake_req_i,
    output logic      rc_tick_o,
    output logic      xtal_tick_o,
    output logic      wake_ext_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int rc_cnt = 0;

    initial
    begin
        rc_tick_o = 1'b0;
        xtal_tick_o = 1'b0;
        wake_ext_o = 1'b0;
    end

    // ==========
    // strobes
    always @(posedge sys_clk_i)
    begin
        rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
        rc_tick_o <= (rc_cnt == RC_PER - 1);
        xtal_tick_o <= ~xtal_tick_o;
        wake_ext_o <= wake_req_i;
    end
endmodule // rspm_env_model

// *** rspm_manager.sv ***
// reset sequencing, cause log, rc divider, watchdog, sleep timer, power modes.
// assumes inputs synchronous to sys_clk_i, ticks one-cycle strobes;
// the register port is reached by on-chip firmware only.
//
// Function
// (R1) separate core and pad power-on inputs
// (R2) always-on reset: pads good, three rc pulses
// (R3) core held in reset while core supply low; not in deep sleep, power down or wake, where core_reset_o stays low
// (R4) count 1024 crystal edges before core release
// (R5) log cause of every reset, readable
// (R6) five causes: por, watchdog, pc, software, dip
// (R7) rc clock divided to 1kHz, programmable ratio
// (R8) watchdog on rc clock, 2s, resets device
// (R9) watchdog reset never leaves the chip
// (R10) only firmware may restart the watchdog
// (R11) 16-bit always-on timer, prescaled 1ms tick
// (R12) timer wraps to zero and continues
// (R13) modes: active, idle, deep sleep, power down
// (R14) idle halts cpu until interrupt, rest runs
// (R15) sleep: radio, regulator and its output off
// (R16) pins frozen throughout sleep
// (R17) regulator re-enabled before resuming on wake
// (R18) deep sleep: timer or external; down: external
// (R19) cause holds until overwritten by next reset
// (R20) timer compare match is the internal wake
module rspm_manager
    import rspm_pkg::*;
#(
    parameter int WDOG_TICKS_P = WDOG_TICKS
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire rspm_bus_req_t     bus_req_i,
    output logic      [DATA_W-1:0] bus_rdata_o,
    input  wire logic              por_pads_ok_i,
    input  wire logic              por_core_ok_i,
    input  wire logic              rc_tick_i,
    input  wire logic              xtal_tick_i,
    input  wire logic              pc_rollover_i,
    input  wire logic              irq_any_i,
    input  wire logic              wake_ext_i,
    input  wire logic [PIN_W-1:0]  pin_val_i,
    output logic      [PIN_W-1:0]  pin_val_o,
    output logic                   aon_reset_o,
    output logic                   core_reset_o,
    output logic                   cpu_halt_o,
    output logic                   radio_en_o,
    output logic                   regulator_en_o,
    output logic                   regulator_output_o
);

    localparam logic [WDOG_W-1:0] WDOG_LIMIT = WDOG_W'(WDOG_TICKS_P - 1);
    localparam logic [9:0]        XTAL_LAST  = 10'(XTAL_EDGES - 1);
    localparam logic [1:0]        RC_NEED    = 2'(RC_PULSES_MIN);

    // ==========
    // declarations
    rspm_rst_state_t     rst_state_reg;
    rspm_pm_state_t      pm_state_reg;
    logic [1:0]          rc_cnt_reg;
    logic [9:0]          xtal_cnt_reg;
    logic [CAUSE_W-1:0]  cause_reg;
    logic [DIV_W-1:0]    div_ratio_reg;
    logic [DIV_W-1:0]    div_cnt_reg;
    logic                tick_1k_reg;
    logic [PRESC_W-1:0]  presc_reg;
    logic [TMR_W-1:0]    cmp_reg;
    logic [WDOG_W-1:0]   wdog_cnt_reg;
    logic                wdog_expire;
    logic [TMR_W-1:0]    tmr_count;
    logic                tmr_match;
    logic                wr_ctrl;
    logic                wr_mode;
    logic                sw_rst;
    logic                kick;
    logic                awake;
    logic                sleeping;
    logic                core_dip;
    logic                run_rst_req;

    // ==========
    // register write decode
    assign wr_ctrl  = bus_req_i.wr && (bus_req_i.addr == OFS_CONTROL);
    assign wr_mode  = bus_req_i.wr && (bus_req_i.addr == OFS_POWER_MODE);
    assign sw_rst   = wr_ctrl && bus_req_i.wdata[CTRL_SWRST_BIT];
    // restart only via this firmware register
    assign kick     = wr_ctrl && bus_req_i.wdata[CTRL_KICK_BIT]; // R10

    assign sleeping = (pm_state_reg == PM_DEEP) || (pm_state_reg == PM_DOWN);
    assign awake    = (pm_state_reg == PM_ACTIVE) || (pm_state_reg == PM_IDLE);

    // core supply loss only counts as a dip while active or idle, not while waking from sleep
    assign core_dip    = (rst_state_reg == RS_RUN) && awake && !por_core_ok_i; // R6
    assign run_rst_req = (rst_state_reg == RS_RUN)
                         && (core_dip || wdog_expire || pc_rollover_i || sw_rst);

    // ==========
    // reset sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            rst_state_reg <= RS_AON;
        else if (!por_pads_ok_i)
            rst_state_reg <= RS_AON; // R1 R2
        else
        begin
            case (rst_state_reg)
                RS_AON:
                begin
                    if (rc_cnt_reg == RC_NEED)
                        rst_state_reg <= RS_CORE_POR; // R2
                end
                RS_CORE_POR:
                begin
                    if (por_core_ok_i)
                        rst_state_reg <= RS_XTAL; // R3
                end
                RS_XTAL:
                begin
                    if (!por_core_ok_i)
                        rst_state_reg <= RS_CORE_POR; // R3
                    else if (xtal_tick_i && (xtal_cnt_reg == XTAL_LAST))
                        rst_state_reg <= RS_RUN; // R4
                end
                RS_RUN:
                begin
                    if (run_rst_req)
                        rst_state_reg <= RS_CORE_POR; // R8
                end
                default:
                    rst_state_reg <= RS_AON;
            endcase
        end
    end

    // rc pulses seen since the pad supply came good
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            rc_cnt_reg <= '0;
        else if (!por_pads_ok_i || (rst_state_reg != RS_AON))
            rc_cnt_reg <= '0;
        else if (rc_tick_i && (rc_cnt_reg != RC_NEED))
            rc_cnt_reg <= rc_cnt_reg + 2'h1; // R2
    end

    // crystal edges after the core supply is good
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            xtal_cnt_reg <= '0;
        else if (rst_state_reg != RS_XTAL)
            xtal_cnt_reg <= '0;
        else if (xtal_tick_i)
            xtal_cnt_reg <= xtal_cnt_reg + 10'h001; // R4
    end

    assign aon_reset_o  = (rst_state_reg == RS_AON); // R2
    // core reset is internal; watchdog resets reach no pin
    assign core_reset_o = (rst_state_reg != RS_RUN); // R3 R9

    // =========================================================================
    // reset cause: overwritten whole on each reset, one bit set
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            cause_reg <= CAUSE_W'(1) << CAUSE_POR_BIT; // R5
        else if ((rst_state_reg == RS_AON) && por_pads_ok_i && (rc_cnt_reg == RC_NEED))
            cause_reg <= CAUSE_W'(1) << CAUSE_POR_BIT; // R5 R19
        else if (run_rst_req)
        begin
            // simultaneous causes: the most severe is reported
            if (core_dip)
                cause_reg <= CAUSE_W'(1) << CAUSE_DIP_BIT; // R6
            else if (wdog_expire)
                cause_reg <= CAUSE_W'(1) << CAUSE_WDOG_BIT; // R6
            else if (pc_rollover_i)
                cause_reg <= CAUSE_W'(1) << CAUSE_PCROL_BIT; // R6
            else
                cause_reg <= CAUSE_W'(1) << CAUSE_SWRST_BIT; // R6 R19
        end
    end

    // =========================================================================
    // configuration registers, kept in the always-on domain
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            div_ratio_reg <= RC_DIV_RESET;
            presc_reg     <= PRESC_RESET;
            cmp_reg       <= CMP_RESET;
        end
        else if (bus_req_i.wr)
        begin
            if (bus_req_i.addr == OFS_RC_DIV)
                div_ratio_reg <= bus_req_i.wdata[DIV_W-1:0]; // R7
            if (bus_req_i.addr == OFS_SLEEP_PRESC)
                presc_reg <= bus_req_i.wdata[PRESC_W-1:0]; // R11
            if (bus_req_i.addr == OFS_SLEEP_CMP)
                cmp_reg <= bus_req_i.wdata[TMR_W-1:0]; // R20
        end
    end

    // =========================================================================
    // rc divider to the calibrated 1 kHz tick; ratio 0 behaves like 1
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            div_cnt_reg <= '0;
            tick_1k_reg <= 1'b0;
        end
        else
        begin
            tick_1k_reg <= 1'b0;
            if (rc_tick_i)
            begin
                if ({1'b0, div_cnt_reg} + 9'h001 >= {1'b0, div_ratio_reg})
                begin
                    div_cnt_reg <= '0;
                    tick_1k_reg <= 1'b1; // R7
                end
                else
                    div_cnt_reg <= div_cnt_reg + 8'h01; // R7
            end
        end
    end

    // =========================================================================
    // watchdog on rc pulses; cleared while the core is in reset, paused while asleep
    assign wdog_expire = (rst_state_reg == RS_RUN) && awake && rc_tick_i
                         && (wdog_cnt_reg == WDOG_LIMIT); // R8

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            wdog_cnt_reg <= '0;
        else if ((rst_state_reg != RS_RUN) || kick || wdog_expire)
            wdog_cnt_reg <= '0; // R10
        else if (awake && rc_tick_i)
            wdog_cnt_reg <= wdog_cnt_reg + 15'h0001; // R8
    end

    // =========================================================================
    // sleep timer
    rspm_sleep_timer u_sleep_timer (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .tick_1k_i (tick_1k_reg),
        .presc_i   (presc_reg),
        .cmp_i     (cmp_reg),
        .count_o   (tmr_count),
        .match_o   (tmr_match)
    );

    // ==========
    // power mode controller
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || (rst_state_reg == RS_AON))
            pm_state_reg <= PM_ACTIVE;
        else
        begin
            case (pm_state_reg)
                PM_ACTIVE:
                begin
                    // sleep is only entered from a running core
                    if (wr_mode && (rst_state_reg == RS_RUN))
                    begin
                        case (bus_req_i.wdata[MODE_W-1:0])
                            MODE_IDLE:
                                pm_state_reg <= PM_IDLE; // R13
                            MODE_DEEP:
                                pm_state_reg <= PM_DEEP; // R13
                            MODE_DOWN:
                                pm_state_reg <= PM_DOWN; // R13
                            default:
                                pm_state_reg <= PM_ACTIVE;
                        endcase
                    end
                end
                PM_IDLE:
                begin
                    if (irq_any_i || (rst_state_reg != RS_RUN))
                        pm_state_reg <= PM_ACTIVE; // R14
                end
                PM_DEEP:
                begin
                    if (wake_ext_i || tmr_match)
                        pm_state_reg <= PM_WAKE; // R18 R20
                end
                PM_DOWN:
                begin
                    if (wake_ext_i)
                        pm_state_reg <= PM_WAKE; // R18
                end
                PM_WAKE:
                begin
                    if (por_core_ok_i)
                        pm_state_reg <= PM_ACTIVE; // R17
                end
                default:
                    pm_state_reg <= PM_ACTIVE;
            endcase
        end
    end

    // idle keeps the radio and everything else running
    assign cpu_halt_o         = (pm_state_reg != PM_ACTIVE); // R14
    assign radio_en_o         = awake; // R14 R15
    assign regulator_en_o     = !sleeping; // R15 R17
    assign regulator_output_o = !sleeping; // R15

    // pins freeze at their last awake value
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            pin_val_o <= '0;
        else if (awake)
            pin_val_o <= pin_val_i; // R16
    end

    // =========================================================================
    // read port: data only in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || !bus_req_i.rd)
            bus_rdata_o <= '0;
        else
        begin
            case (bus_req_i.addr)
                OFS_RESET_CAUSE:
                    bus_rdata_o <= DATA_W'(cause_reg); // R5
                OFS_RC_DIV:
                    bus_rdata_o <= DATA_W'(div_ratio_reg);
                OFS_SLEEP_PRESC:
                    bus_rdata_o <= DATA_W'(presc_reg);
                OFS_SLEEP_CMP:
                    bus_rdata_o <= DATA_W'(cmp_reg);
                OFS_SLEEP_COUNT:
                    bus_rdata_o <= DATA_W'(tmr_count); // R12
                OFS_POWER_MODE:
                    bus_rdata_o <= DATA_W'(pm_state_reg);
                default:
                    bus_rdata_o <= '0;
            endcase
        end
    end

endmodule // rspm_manager

// *** rspm_manager_bench.sv ***
// self-checking bench of the power manager.
// assumes package, design, checker and model compiled before it.
module rspm_manager_bench
    import rspm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WDOG_SIM = 64;

    logic              sys_clk_i = 1'b0;
    logic              reset_i = 1'b1;
    rspm_bus_req_t     bus_req_i = '0;
    logic [DATA_W-1:0] bus_rdata_o;
    logic              por_pads_ok_i = 1'b1;
    logic              por_core_ok_i = 1'b1;
    logic              rc_tick_i;
    logic              xtal_tick_i;
    logic              pc_rollover_i = 1'b0;
    logic              irq_any_i = 1'b0;
    logic              wake_req = 1'b0;
    logic              wake_ext_i;
    logic [PIN_W-1:0]  pin_val_i = '0;
    logic [PIN_W-1:0]  pin_val_o;
    logic              aon_reset_o;
    logic              core_reset_o;
    logic              cpu_halt_o;
    logic              radio_en_o;
    logic              regulator_en_o;
    logic              regulator_output_o;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] c0;
    int                fail_count = 0;
    int                n_tests = 0;
    int                k;
    int                d;
    int                p;

    always #5 sys_clk_i = ~sys_clk_i;

    rspm_manager #(.WDOG_TICKS_P(WDOG_SIM)) DUT (.*);

    rspm_env_model #(.RC_PER(10)) u_env (
        .sys_clk_i, .wake_req_i(wake_req), .rc_tick_o(rc_tick_i),
        .xtal_tick_o(xtal_tick_i), .wake_ext_o(wake_ext_i)
    );

    // ==========
    // helpers
    function automatic int win(input int dv, input int pv);
        return 40 * dv * (1 << pv);
    endfunction

    function automatic logic pick(input int s);
        return (s == 0) ? core_reset_o : regulator_en_o;
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic bus(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dt, input logic w);
        @(posedge sys_clk_i);
        bus_req_i <= '{a, dt, w, !w};
        @(posedge sys_clk_i);
        bus_req_i <= '0;
        #1 v = bus_rdata_o;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus(a, '0, 1'b0);
        chk(v, exp);
    endtask

    task automatic wait_for(input int s, input logic lvl, input int lim);
        for (int i = 0; i < lim && pick(s) !== lvl; i++)
        begin
            @(posedge sys_clk_i);
            #1;
        end
        if (pick(s) !== lvl)
        begin
            chk(pick(s), lvl);
            test_done();
        end
    endtask

    // ==========
    // sequence
    initial
    begin
        void'($urandom(9752));
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        wait_for(0, 1'b0, 4000);
        chk(aon_reset_o, 1'b0);
        rd(OFS_RESET_CAUSE, 32'h00000001);
        rd(OFS_RC_DIV, RC_DIV_RESET);
        rd(OFS_SLEEP_PRESC, PRESC_RESET);
        rd(OFS_SLEEP_CMP, CMP_RESET);
        rd(8'h1C, 32'h00000000);
        $display("power-on test done");
        // pads loss, watchdog, pc rollover, software, core dip
        for (k = 0; k < 5; k++)
        begin
            bus(OFS_CONTROL, 32'h00000002, 1'b1);
            if (k == 1)
            begin
                repeat (WDOG_SIM * 10 - 40) @(posedge sys_clk_i);
                #1 chk(core_reset_o, 1'b0);
            end
            if (k == 3)
                bus(OFS_CONTROL, 32'h00000001, 1'b1);
            @(posedge sys_clk_i);
            por_pads_ok_i <= (k != 0);
            por_core_ok_i <= (k != 4);
            pc_rollover_i <= (k == 2);
            wait_for(0, 1'b1, 700);
            por_pads_ok_i <= 1'b1;
            por_core_ok_i <= 1'b1;
            pc_rollover_i <= 1'b0;
            wait_for(0, 1'b0, 4000);
            rd(OFS_RESET_CAUSE, 32'h00000001 << k);
            rd(OFS_RESET_CAUSE, 32'h00000001 << k);
        end
        $display("reset cause test done");
        for (k = 0; k < 4; k++)
        begin
            // restart first: two windows would outlast the short watchdog
            bus(OFS_CONTROL, 32'h2, 1'b1);
            d = 1 + $urandom % 3;
            p = $urandom % 3;
            pin_val_i <= PIN_W'($urandom);
            bus(OFS_RC_DIV, d, 1'b1);
            bus(OFS_SLEEP_PRESC, p, 1'b1);
            rd(OFS_RC_DIV, d);
            rd(OFS_SLEEP_PRESC, p);
            repeat (win(d, p)) @(posedge sys_clk_i);
            bus(OFS_CONTROL, 32'h2, 1'b1);
            bus(OFS_SLEEP_COUNT, '0, 1'b0);
            c0 = v;
            // the two reads sample exactly one window apart
            repeat (win(d, p) - 2) @(posedge sys_clk_i);
            rd(OFS_SLEEP_COUNT, c0 + 4);
        end
        $display("divider test done");
        bus(OFS_POWER_MODE, MODE_IDLE, 1'b1);
        chk({cpu_halt_o, radio_en_o}, 2'h3);
        rd(OFS_POWER_MODE, MODE_IDLE);
        @(posedge sys_clk_i);
        irq_any_i <= 1'b1;
        @(posedge sys_clk_i);
        irq_any_i <= 1'b0;
        #1 chk(cpu_halt_o, 1'b0);
        $display("idle test done");
        // deep sleep wakes on the timer, power down ignores it
        for (k = 0; k < 2; k++)
        begin
            bus(OFS_CONTROL, 32'h00000002, 1'b1);
            bus(OFS_SLEEP_COUNT, '0, 1'b0);
            bus(OFS_SLEEP_CMP, v + 2, 1'b1);
            bus(OFS_POWER_MODE, k ? MODE_DOWN : MODE_DEEP, 1'b1);
            chk({radio_en_o, regulator_en_o, regulator_output_o}, 3'h0);
            c0 = pin_val_o;
            @(posedge sys_clk_i);
            pin_val_i <= ~pin_val_i;
            if (k == 1)
            begin
                repeat (4 * win(d, p)) @(posedge sys_clk_i);
                chk(regulator_en_o, 1'b0);
                wake_req <= 1'b1;
            end
            wait_for(1, 1'b1, 800);
            chk(pin_val_o, c0);
            chk(cpu_halt_o, 1'b1);
            wake_req <= 1'b0;
            wait_for(0, 1'b0, 10);
            @(posedge sys_clk_i);
            #1 chk(cpu_halt_o, 1'b0);
        end
        $display("sleep test done");
        test_done();
    end
endmodule // rspm_manager_bench

// *** rspm_manager_monitor.sv ***
// port checker of the power manager.
// assumes one-cycle tick strobes on sys_clk_i.
module rspm_manager_monitor
    import rspm_pkg::*;
#(
    parameter int WDOG_TICKS_P = WDOG_TICKS
)
(
    input wire logic             sys_clk_i,
    input wire logic             reset_i,
    input wire rspm_bus_req_t    bus_req_i,
    input wire logic             por_pads_ok_i,
    input wire logic             por_core_ok_i,
    input wire logic             rc_tick_i,
    input wire logic             xtal_tick_i,
    input wire logic             pc_rollover_i,
    input wire logic             irq_any_i,
    input wire logic [PIN_W-1:0] pin_val_i,
    input wire logic [PIN_W-1:0] pin_val_o,
    input wire logic             aon_reset_o,
    input wire logic             core_reset_o,
    input wire logic             cpu_halt_o,
    input wire logic             radio_en_o,
    input wire logic             regulator_en_o,
    input wire logic             regulator_output_o
);
    // ==========
    // helper counts
    logic kick;
    int   rc_seen_reg;
    int   xt_seen_reg;
    int   wd_seen_reg;

    assign kick = bus_req_i.wr && bus_req_i.addr == OFS_CONTROL
                  && bus_req_i.wdata[CTRL_KICK_BIT];

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || !por_pads_ok_i || !aon_reset_o)
            rc_seen_reg <= 0;
        else if (rc_tick_i)
            rc_seen_reg <= rc_seen_reg + 1;
    end

    // may run one edge ahead of the design: lower bound only
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || !core_reset_o || aon_reset_o || !por_core_ok_i)
            xt_seen_reg <= 0;
        else if (xtal_tick_i)
            xt_seen_reg <= xt_seen_reg + 1;
    end

    // held, not cleared, while asleep
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || core_reset_o || kick)
            wd_seen_reg <= 0;
        else if (rc_tick_i && radio_en_o)
            wd_seen_reg <= wd_seen_reg + 1;
    end

    // ==========
    // properties
    default clocking mon_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_idle_irq;
        cpu_halt_o && radio_en_o && irq_any_i;
    endsequence

    sequence s_asleep;
        !regulator_en_o ##1 !regulator_en_o;
    endsequence

    a_aon_pads_low: assert property (!por_pads_ok_i |=> aon_reset_o)
        else $error("aon without pads");
    a_aon_rc_pulses: assert property ($fell(aon_reset_o) |-> rc_seen_reg >= 3)
        else $error("aon early release");
    a_core_under_aon: assert property (aon_reset_o |-> core_reset_o)
        else $error("core out under aon");
    a_core_xtal_wait: assert property ($fell(core_reset_o) |-> xt_seen_reg >= 1024)
        else $error("core early release");
    a_core_dip: assert property (!por_core_ok_i && radio_en_o && !core_reset_o |-> ##[1:2] core_reset_o)
        else $error("dip missed");
    a_pc_rollover: assert property (pc_rollover_i && !cpu_halt_o && !core_reset_o |-> ##[1:2] core_reset_o)
        else $error("rollover missed");
    a_wdog_expiry: assert property (rc_tick_i && radio_en_o && !core_reset_o && !kick
        && wd_seen_reg == WDOG_TICKS_P - 1 |-> ##[1:2] core_reset_o)
        else $error("watchdog missed");
    a_sleep_power_off: assert property (!regulator_en_o |-> !regulator_output_o && !radio_en_o && cpu_halt_o)
        else $error("sleep outputs on");
    a_pins_frozen: assert property (s_asleep |-> $stable(pin_val_o))
        else $error("pins moved asleep");
    a_pins_follow: assert property (radio_en_o && !core_reset_o |=> pin_val_o == $past(pin_val_i))
        else $error("pins not following");
    a_idle_irq_wake: assert property (s_idle_irq |=> !cpu_halt_o)
        else $error("idle not ended");
    a_wake_halted: assert property ($rose(regulator_en_o) && !core_reset_o |-> cpu_halt_o)
        else $error("cpu ran before regulator");
endmodule // rspm_manager_monitor

bind rspm_manager rspm_manager_monitor #(.WDOG_TICKS_P(WDOG_TICKS_P)) u_monitor (.*);

// *** rspm_pkg.sv ***
// shared constants and types of the power manager.
// assumes one 100 MHz clock, strobes synchronous to it.
package rspm_pkg;

    // ==========
    // bus and pin widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_W  = 16;

    // ==========
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RC_DIV      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_PRESC = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_CMP   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_POWER_MODE  = 8'h18;

    // ==========
    // fields
    localparam int CAUSE_W         = 5;
    localparam int CAUSE_POR_BIT   = 0;
    localparam int CAUSE_WDOG_BIT  = 1;
    localparam int CAUSE_PCROL_BIT = 2;
    localparam int CAUSE_SWRST_BIT = 3;
    localparam int CAUSE_DIP_BIT   = 4;
    localparam int CTRL_SWRST_BIT  = 0;
    localparam int CTRL_KICK_BIT   = 1;
    localparam int DIV_W           = 8;
    localparam int PRESC_W         = 4;
    localparam int TMR_W           = 16;
    localparam int MODE_W          = 2;

    localparam logic [MODE_W-1:0] MODE_ACTIVE = 2'h0;
    localparam logic [MODE_W-1:0] MODE_IDLE   = 2'h1;
    localparam logic [MODE_W-1:0] MODE_DEEP   = 2'h2;
    localparam logic [MODE_W-1:0] MODE_DOWN   = 2'h3;

    // ==========
    // reset values
    localparam logic [DIV_W-1:0]   RC_DIV_RESET = 8'h0A;
    localparam logic [PRESC_W-1:0] PRESC_RESET  = 4'h0;
    localparam logic [TMR_W-1:0]   CMP_RESET    = 16'hFFFF;

    // ==========
    // timing
    localparam int RC_PULSES_MIN   = 3;
    localparam int XTAL_EDGES      = 1024;
    localparam int RC_FREQ_HZ      = 10000;
    localparam int WDOG_TIMEOUT_MS = 2000;
    localparam int WDOG_TICKS      = RC_FREQ_HZ / 1000 * WDOG_TIMEOUT_MS;
    localparam int WDOG_W          = 15;

    // ==========
    // types
    typedef enum logic [1:0] {
        RS_AON,
        RS_CORE_POR,
        RS_XTAL,
        RS_RUN
    } rspm_rst_state_t;

    typedef enum logic [2:0] {
        PM_ACTIVE,
        PM_IDLE,
        PM_DEEP,
        PM_DOWN,
        PM_WAKE
    } rspm_pm_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } rspm_bus_req_t;

endpackage

// *** rspm_sleep_timer.sv ***
// 16-bit sleep timer with power-of-two prescaler and compare match.
// assumes tick_1k_i is a one-cycle 1 kHz strobe.
module rspm_sleep_timer
    import rspm_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic               tick_1k_i,
    input  wire logic [PRESC_W-1:0] presc_i,
    input  wire logic [TMR_W-1:0]   cmp_i,
    output logic      [TMR_W-1:0]   count_o,
    output logic                    match_o
);

    // ==========
    // prescaler
    logic [TMR_W-1:0] presc_cnt_reg;
    logic [TMR_W-1:0] presc_lim;
    logic             ms_tick;

    assign presc_lim = TMR_W'((32'h1 << presc_i) - 32'h1);
    assign ms_tick   = tick_1k_i && (presc_cnt_reg >= presc_lim);

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            presc_cnt_reg <= '0;
        else if (ms_tick)
            presc_cnt_reg <= '0;
        else if (tick_1k_i)
            presc_cnt_reg <= presc_cnt_reg + 16'h0001; // R11
    end

    // ==========
    // counter; natural overflow wraps to zero and keeps going
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            count_o <= '0;
        else if (ms_tick)
            count_o <= count_o + 16'h0001; // R11 R12
    end

    // one pulse per match, only when the counter moves onto the value
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            match_o <= 1'b0;
        else
            match_o <= ms_tick && ((count_o + 16'h0001) == cmp_i); // R20
    end

endmodule // rspm_sleep_timer
